// File: rtl/enc_fb_pkg.sv
package enc_fb_pkg;
    // register byte offsets
    localparam logic [7:0] off_type = 8'h00;
    localparam logic [7:0] off_supply = 8'h04;
    localparam logic [7:0] off_lines = 8'h08;
    localparam logic [7:0] off_term = 8'h0c;
    localparam logic [7:0] off_errlvl = 8'h10;
    localparam logic [7:0] off_auto = 8'h14;
    localparam logic [7:0] off_rate = 8'h18;
    localparam logic [7:0] off_turns = 8'h1c;
    localparam logic [7:0] off_res = 8'h20;
    localparam logic [7:0] off_decode = 8'h24;
    localparam logic [7:0] off_status = 8'h28;
    localparam logic [7:0] off_mask = 8'h2c;
    localparam logic [7:0] off_count = 8'h30;

    // feedback type codes
    localparam logic [3:0] quadrature_plain_type = 4'h0;
    localparam logic [3:0] rate_direction_type = 4'h1;
    localparam logic [3:0] two_pulse_type = 4'h2;
    localparam logic [3:0] quadrature_commutation_type = 4'h3;
    localparam logic [3:0] rate_direction_commutation_type = 4'h4;
    localparam logic [3:0] two_pulse_commutation_type = 4'h5;
    localparam logic [3:0] sinusoidal_only_type = 4'h6;
    localparam logic [3:0] sinusoidal_serial_type_a = 4'h7;

    // supply codes, in volts
    localparam logic [1:0] supply_5v = 2'h0;
    localparam logic [1:0] supply_8v = 2'h1;
    localparam logic [1:0] supply_15v = 2'h2;

    // termination codes
    localparam logic [1:0] term_none = 2'h0;
    localparam logic [1:0] term_pulse = 2'h1;
    localparam logic [1:0] term_all = 2'h2;

    // serial bit rate codes
    localparam logic [11:0] rate_100k = 12'h064;
    localparam logic [11:0] rate_200k = 12'h0c8;
    localparam logic [11:0] rate_300k = 12'h12c;
    localparam logic [11:0] rate_500k = 12'h1f4;
    localparam logic [11:0] rate_1m = 12'h3e8;
    localparam logic [11:0] rate_1m5 = 12'h5dc;
    localparam logic [11:0] rate_2m = 12'h7d0;

    // reset values
    localparam logic [3:0] type_rst = 4'h0;
    localparam logic [15:0] lines_rst = 16'h0400;
    localparam logic [11:0] rate_rst = 12'h12c;
    localparam logic [4:0] turns_rst = 5'h10;
    localparam logic [4:0] res_rst = 5'h11;

    // status bits
    localparam int st_wire = 0;
    localparam int st_phase = 1;
    localparam int st_rate = 2;

    typedef struct packed {
        logic pulse_a;     // quadrature a, rate, or cw line
        logic pulse_b;     // quadrature b, direction, or ccw line
        logic index;
        logic sin_ok;      // sine signal present
        logic cos_ok;      // cosine signal present
        logic [2:0] comm;  // u v w commutation lines
    } enc_in_t;

    typedef struct packed {
        logic term_ab;
        logic term_z;
        logic [1:0] supply;
        logic use_comm;
        logic serial_en;
        logic wire_chk;
        logic phase_chk;
    } enc_ctl_t;
endpackage

// File: rtl/encoder_feedback_config.sv
`timescale 1ns/1ps
// How it works
// - type 1 rate/direction, 4 with commutation
// - type 2 two pulses, 5 with commutation
// - supply code 0/1/2 gives 5V/8V/15V
// - termination 0 none, 1 pulses, 2 all
// - error level: wire break, phase, both
// - pulse types: phase only with commutation; wire needs termination
// - type 7 sinusoidal with serial channel
// - auto configure fills turns, lines, resolution on sinusoidal types 6/7
// - bit rate codes map to 100k..2M
// - sinusoidal wire break level checks sine, cosine; phase level checks the pulse pair
// - type 0 quadrature, 3 commutated, 6 sinusoidal
module encoder_feedback_config #(
    parameter logic [4:0] auto_turns = 5'h0c, // turns reported by encoder
    parameter logic [4:0] auto_res = 5'h0d,   // resolution from encoder
    parameter logic [15:0] auto_lines = 16'h0400 // lines from encoder
) (
    input wire logic pclk, // bus clock, 250 MHz
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire enc_fb_pkg::enc_in_t enc_pins, // encoder pins
    output enc_fb_pkg::enc_ctl_t enc_ctl, // decoded controls
    output logic [31:0] position, // position count
    output logic [2:0] comm_state, // sampled commutation
    output logic irq // level interrupt
);
    localparam logic [3:0] wb_limit = 4'hf;

    logic [3:0] type_q;
    logic [1:0] supply_q;
    logic [15:0] lines_q;
    logic [1:0] term_q;
    logic [1:0] errlvl_q;
    logic auto_q;
    logic [11:0] rate_q;
    logic [4:0] turns_q;
    logic [4:0] res_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [3:0] route_type_q;
    enc_fb_pkg::enc_in_t sync1_q, sync2_q, prev_q;
    logic [31:0] position_q;
    logic [2:0] comm_q;
    logic [3:0] wb_cnt_q;
    logic [2:0] rate_div_q;
    logic rate_valid;
    logic [3:0] rate_code;
    logic wire_ev, phase_ev;
    logic wr, rd;

    function automatic logic has_comm(input logic [3:0] t);
        has_comm = (t == enc_fb_pkg::quadrature_commutation_type) ||
            (t == enc_fb_pkg::rate_direction_commutation_type) ||
            (t == enc_fb_pkg::two_pulse_commutation_type);
    endfunction

    function automatic logic is_sin(input logic [3:0] t);
        is_sin = (t == enc_fb_pkg::sinusoidal_only_type) ||
            (t == enc_fb_pkg::sinusoidal_serial_type_a);
    endfunction

    // bit rate code decode into divider select
    function automatic logic [3:0] rate_sel(input logic [11:0] c);
        case (c)
            enc_fb_pkg::rate_100k: rate_sel = 4'h1;
            enc_fb_pkg::rate_200k: rate_sel = 4'h2;
            enc_fb_pkg::rate_300k: rate_sel = 4'h3;
            enc_fb_pkg::rate_500k: rate_sel = 4'h4;
            enc_fb_pkg::rate_1m: rate_sel = 4'h5;
            enc_fb_pkg::rate_1m5: rate_sel = 4'h6;
            enc_fb_pkg::rate_2m: rate_sel = 4'h7;
            default: rate_sel = 4'h0;
        endcase
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign rate_code = rate_sel(rate_q);
    assign rate_valid = rate_code[2:0] != 3'h0;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable && paddr > enc_fb_pkg::off_count) begin
            pslverr = 1'b1;
        end
    end

    // configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_q <= enc_fb_pkg::type_rst;
            supply_q <= enc_fb_pkg::supply_5v;
            term_q <= enc_fb_pkg::term_none;
            errlvl_q <= 2'h0;
            auto_q <= 1'b0;
            rate_q <= enc_fb_pkg::rate_rst;
        end else if (wr) begin
            case (paddr)
                enc_fb_pkg::off_type: type_q <= pwdata[3:0];
                enc_fb_pkg::off_supply: begin
                    // code 3 is not a supply; hold last value
                    if (pwdata[1:0] != 2'h3) begin
                        supply_q <= pwdata[1:0];
                    end
                end
                enc_fb_pkg::off_term: begin
                    if (pwdata[1:0] != 2'h3) begin
                        term_q <= pwdata[1:0];
                    end
                end
                enc_fb_pkg::off_errlvl: errlvl_q <= pwdata[1:0];
                enc_fb_pkg::off_auto: auto_q <= pwdata[0];
                enc_fb_pkg::off_rate: rate_q <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // auto configure overrides manual values each cycle it is set on a sinusoidal type
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lines_q <= enc_fb_pkg::lines_rst;
            turns_q <= enc_fb_pkg::turns_rst;
            res_q <= enc_fb_pkg::res_rst;
        end else if (auto_q && is_sin(type_q)) begin
            lines_q <= auto_lines;
            turns_q <= auto_turns;
            res_q <= auto_res;
        end else if (wr) begin
            if (paddr == enc_fb_pkg::off_lines) begin
                lines_q <= pwdata[15:0];
            end
            if (paddr == enc_fb_pkg::off_turns) begin
                turns_q <= pwdata[4:0];
            end
            if (paddr == enc_fb_pkg::off_res) begin
                res_q <= pwdata[4:0];
            end
        end
    end

    // routing latched only on a type change, never mid-count glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_type_q <= enc_fb_pkg::type_rst;
        end else if (route_type_q != type_q) begin
            route_type_q <= type_q;
        end
    end

    always_comb begin
        enc_ctl.supply = supply_q;
        enc_ctl.term_ab = term_q != enc_fb_pkg::term_none;
        enc_ctl.term_z = term_q == enc_fb_pkg::term_all;
        enc_ctl.use_comm = has_comm(route_type_q);
        enc_ctl.serial_en =
            route_type_q == enc_fb_pkg::sinusoidal_serial_type_a;
        // pulse types: wire break needs terminations on the pulse pair
        enc_ctl.wire_chk = errlvl_q[0] &&
            (is_sin(route_type_q) || term_q != enc_fb_pkg::term_none);
        // pulse types: phase check only with commutation lines
        enc_ctl.phase_chk = errlvl_q[1] &&
            (is_sin(route_type_q) || has_comm(route_type_q));
    end

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= enc_pins;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // position counter, per input style
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_q <= 32'h0;
        end else begin
            case (route_type_q)
                enc_fb_pkg::rate_direction_type,
                enc_fb_pkg::rate_direction_commutation_type: begin
                    if (sync2_q.pulse_a && !prev_q.pulse_a) begin
                        position_q <= sync2_q.pulse_b ?
                            position_q - 32'h1 : position_q + 32'h1;
                    end
                end
                enc_fb_pkg::two_pulse_type,
                enc_fb_pkg::two_pulse_commutation_type: begin
                    if (sync2_q.pulse_a && !prev_q.pulse_a) begin
                        position_q <= position_q + 32'h1;
                    end else if (sync2_q.pulse_b && !prev_q.pulse_b) begin
                        position_q <= position_q - 32'h1;
                    end
                end
                default: begin
                    if (sync2_q.pulse_a != prev_q.pulse_a) begin
                        position_q <= (sync2_q.pulse_a ^ sync2_q.pulse_b) ?
                            position_q - 32'h1 : position_q + 32'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comm_q <= 3'h0;
        end else if (has_comm(route_type_q)) begin
            comm_q <= sync2_q.comm;
        end
    end

    // wire break: both pulse lines (and index when all terminated) stuck high, or sine/cosine lost, beyond a short limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_cnt_q <= 4'h0;
        end else if (!enc_ctl.wire_chk) begin
            wb_cnt_q <= 4'h0;
        end else if (is_sin(route_type_q) ?
                (!sync2_q.sin_ok || !sync2_q.cos_ok) :
                (sync2_q.pulse_a && sync2_q.pulse_b &&
                 (sync2_q.index || !enc_ctl.term_z))) begin
            if (wb_cnt_q != wb_limit) begin
                wb_cnt_q <= wb_cnt_q + 4'h1;
            end
        end else begin
            wb_cnt_q <= 4'h0;
        end
    end

    assign wire_ev = enc_ctl.wire_chk && wb_cnt_q == wb_limit - 4'h1;
    // both pulse lines toggling together is a phase fault
    assign phase_ev = enc_ctl.phase_chk &&
        sync2_q.pulse_a != prev_q.pulse_a &&
        sync2_q.pulse_b != prev_q.pulse_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_div_q <= 3'h0;
        end else begin
            rate_div_q <= rate_code[2:0];
        end
    end

    // sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 3'h0;
        end else begin
            status_q <= (status_q &
                ~((wr && paddr == enc_fb_pkg::off_status) ?
                  pwdata[2:0] : 3'h0)) |
                {enc_ctl.serial_en && !rate_valid, phase_ev, wire_ev};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 3'h0;
        end else if (wr && paddr == enc_fb_pkg::off_mask) begin
            mask_q <= pwdata[2:0];
        end
    end

    // a set mask bit hides its event from the interrupt
    assign irq = |(status_q & ~mask_q);
    assign position = position_q;
    assign comm_state = comm_q;

    // read data captured in setup so it stands from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd) begin
            case (paddr)
                enc_fb_pkg::off_type: prdata <= {28'h0, type_q};
                enc_fb_pkg::off_supply: prdata <= {30'h0, supply_q};
                enc_fb_pkg::off_lines: prdata <= {16'h0, lines_q};
                enc_fb_pkg::off_term: prdata <= {30'h0, term_q};
                enc_fb_pkg::off_errlvl: prdata <= {30'h0, errlvl_q};
                enc_fb_pkg::off_auto: prdata <= {31'h0, auto_q};
                enc_fb_pkg::off_rate: prdata <= {20'h0, rate_q};
                enc_fb_pkg::off_turns: prdata <= {27'h0, turns_q};
                enc_fb_pkg::off_res: prdata <= {27'h0, res_q};
                enc_fb_pkg::off_decode:
                    prdata <= {21'h0, rate_div_q, enc_ctl};
                enc_fb_pkg::off_status: prdata <= {29'h0, status_q};
                enc_fb_pkg::off_mask: prdata <= {29'h0, mask_q};
                enc_fb_pkg::off_count: prdata <= position_q;
                default: prdata <= 32'h0;
            endcase
        end
    end

    a_phase_needs_comm: assert property (@(posedge pclk) disable iff (!presetn)
        enc_ctl.phase_chk && !is_sin(route_type_q) |->
        has_comm(route_type_q) && errlvl_q[1])
        else $error("phase check on uncommutated pulse type");
    a_wire_needs_term: assert property (@(posedge pclk) disable iff (!presetn)
        enc_ctl.wire_chk && !is_sin(route_type_q) |->
        term_q != enc_fb_pkg::term_none)
        else $error("wire check without terminations");
    a_term_decode: assert property (@(posedge pclk) disable iff (!presetn)
        enc_ctl.term_z |-> enc_ctl.term_ab)
        else $error("index terminated without pulse pair");
    a_route_follows: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(type_q) |=> route_type_q == $past(type_q))
        else $error("routing did not follow type change");
    a_route_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(type_q) && route_type_q == type_q |=> $stable(route_type_q))
        else $error("routing changed without type change");
    a_auto_fill: assert property (@(posedge pclk) disable iff (!presetn)
        auto_q && is_sin(type_q) |=> turns_q == auto_turns &&
        res_q == auto_res && lines_q == auto_lines)
        else $error("auto configure did not fill settings");
    a_serial_type7: assert property (@(posedge pclk) disable iff (!presetn)
        enc_ctl.serial_en |-> route_type_q == 4'h7)
        else $error("serial channel on wrong type");
    a_rate_map: assert property (@(posedge pclk) disable iff (!presetn)
        rate_q == enc_fb_pkg::rate_2m ##1 rate_q == enc_fb_pkg::rate_2m
        |-> rate_div_q == 3'h7)
        else $error("bit rate code decoded wrong");
    a_wire_event: assert property (@(posedge pclk) disable iff (!presetn)
        wire_ev |=> status_q[enc_fb_pkg::st_wire])
        else $error("wire break not recorded");
    a_supply_code: assert property (@(posedge pclk) disable iff (!presetn)
        enc_ctl.supply != 2'h3)
        else $error("illegal supply code");
endmodule // encoder_feedback_config

// File: tb/enc_model.sv
`timescale 1ns/1ps
// encoder lines; mode 0 running, 1 wires broken, 2 phase fault
module enc_model (
    input wire logic pclk, // drive clock
    input wire logic [1:0] mode, // fault mode
    output enc_fb_pkg::enc_in_t pins // encoder lines
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge pclk) begin
        cnt_q <= cnt_q + 8'h01;
    end
    always_comb begin
        pins.pulse_a = (mode == 2'h1) | cnt_q[1];
        // direction held low so a running encoder never looks broken
        pins.pulse_b = (mode == 2'h1) | ((mode == 2'h2) & cnt_q[1]);
        pins.index = (mode == 2'h1) | (mode == 2'h0 && cnt_q == 8'h00);
        pins.sin_ok = (mode != 2'h1);
        pins.cos_ok = (mode != 2'h1);
        pins.comm = 3'h5; // held still so sampling can be judged
    end
endmodule // enc_model

// File: tb/encoder_feedback_config_tb_top.sv
`timescale 1ns/1ps
module encoder_feedback_config_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, position;
    logic [2:0] comm_state;
    logic [1:0] mode;
    enc_fb_pkg::enc_in_t enc_pins;
    enc_fb_pkg::enc_ctl_t enc_ctl;
    int errors = 0;
    int checks_done = 0;

    encoder_feedback_config #(.auto_lines(16'h0800)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_pins(enc_pins),
        .enc_ctl(enc_ctl), .position(position), .comm_state(comm_state),
        .irq(irq));
    enc_model model (.pclk(pclk), .mode(mode), .pins(enc_pins));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask

    task automatic ctl_chk(input logic [7:0] exp);
        @(negedge pclk);
        chk({24'h0, enc_ctl}, {24'h0, exp});
        @(posedge pclk);
    endtask

    task automatic irq_chk(input logic exp);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge pclk);
    endtask

    function automatic logic [7:0] want(input int t, lvl, term, sup);
        enc_fb_pkg::enc_ctl_t c;
        logic comm;
        comm = (t >= 3 && t <= 5);
        c.term_ab = (term != 0);
        c.term_z = (term == 2);
        c.supply = sup[1:0];
        c.use_comm = comm;
        c.serial_en = (t == 7);
        c.wire_chk = lvl[0] && (term != 0 || t == 6 || t == 7);
        c.phase_chk = lvl[1] && (comm || t == 6 || t == 7);
        return c;
    endfunction

    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd_chk(enc_fb_pkg::off_type, 32'hf, 32'h0);
        rd_chk(enc_fb_pkg::off_lines, 32'hffff, 32'h400);
        rd_chk(enc_fb_pkg::off_rate, 32'hfff, 32'h12c);
        rd_chk(enc_fb_pkg::off_turns, 32'h1f, 32'h10);
        rd_chk(enc_fb_pkg::off_res, 32'h1f, 32'h11);
        rd_chk(enc_fb_pkg::off_decode, 32'hff, 32'h0);
        ctl_chk(8'h00);
        irq_chk(1'b0);
        xfer(1'b0, 8'h34, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_types;
        wr(enc_fb_pkg::off_term, 32'h2);
        for (int t = 0; t < 8; t++) begin
            for (int l = 0; l < 4; l++) begin
                wr(enc_fb_pkg::off_type, 32'(t));
                wr(enc_fb_pkg::off_errlvl, 32'(l));
                ctl_chk(want(t, l, 2, 0));
            end
        end
        rd_chk(enc_fb_pkg::off_decode, 32'hff, 32'(want(7, 3, 2, 0)));
        wr(enc_fb_pkg::off_type, 32'h1); // rate/direction type assumed
        wr(enc_fb_pkg::off_errlvl, 32'h1);
        wr(enc_fb_pkg::off_term, 32'h0);
        ctl_chk(want(1, 1, 0, 0));
        wr(enc_fb_pkg::off_term, 32'h1);
        ctl_chk(want(1, 1, 1, 0));
        wr(enc_fb_pkg::off_term, 32'h3);
        ctl_chk(want(1, 1, 1, 0));
        $display("test types done");
    endtask

    task automatic t_supply;
        wr(enc_fb_pkg::off_term, 32'h0); // swing above 5V, terminations off
        for (int s = 0; s < 3; s++) begin
            wr(enc_fb_pkg::off_supply, 32'(s));
            ctl_chk(want(1, 1, 0, s));
        end
        wr(enc_fb_pkg::off_supply, 32'h3);
        rd_chk(enc_fb_pkg::off_supply, 32'h3, 32'h2);
        wr(enc_fb_pkg::off_supply, 32'h0);
        $display("test supply done");
    endtask

    task automatic t_rate;
        logic [11:0] codes [7] = '{enc_fb_pkg::rate_100k,
            enc_fb_pkg::rate_200k, enc_fb_pkg::rate_300k,
            enc_fb_pkg::rate_500k, enc_fb_pkg::rate_1m,
            enc_fb_pkg::rate_1m5, enc_fb_pkg::rate_2m};
        wr(enc_fb_pkg::off_errlvl, 32'h0);
        wr(enc_fb_pkg::off_type, 32'h7);
        wr(enc_fb_pkg::off_status, 32'h7);
        foreach (codes[i]) begin
            wr(enc_fb_pkg::off_rate, {20'h0, codes[i]});
            rd_chk(enc_fb_pkg::off_rate, 32'hfff, {20'h0, codes[i]});
        end
        rd_chk(enc_fb_pkg::off_status, 32'h4, 32'h0);
        wr(enc_fb_pkg::off_rate, 32'h0fa);
        repeat (4) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h4, 32'h4);
        wr(enc_fb_pkg::off_rate, {20'h0, enc_fb_pkg::rate_1m});
        wr(enc_fb_pkg::off_status, 32'h4);
        rd_chk(enc_fb_pkg::off_status, 32'h4, 32'h0);
        $display("test rate done");
    endtask

    task automatic t_auto;
        wr(enc_fb_pkg::off_auto, 32'h1);
        repeat (4) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_turns, 32'h1f, 32'h0c);
        rd_chk(enc_fb_pkg::off_res, 32'h1f, 32'h0d);
        rd_chk(enc_fb_pkg::off_lines, 32'hffff, 32'h0800);
        wr(enc_fb_pkg::off_turns, 32'h3);
        rd_chk(enc_fb_pkg::off_turns, 32'h1f, 32'h0c);
        wr(enc_fb_pkg::off_auto, 32'h0);
        wr(enc_fb_pkg::off_turns, 32'h3);
        rd_chk(enc_fb_pkg::off_turns, 32'h1f, 32'h03);
        wr(enc_fb_pkg::off_type, 32'h1);
        wr(enc_fb_pkg::off_lines, 32'h200); // 1024 pulses a turn, halved
        rd_chk(enc_fb_pkg::off_lines, 32'hffff, 32'h200);
        $display("test auto done");
    endtask

    task automatic t_wire;
        wr(enc_fb_pkg::off_errlvl, 32'h1);
        wr(enc_fb_pkg::off_term, 32'h0);
        wr(enc_fb_pkg::off_mask, 32'h0);
        wr(enc_fb_pkg::off_status, 32'h7);
        mode <= 2'h1;
        repeat (25) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h1, 32'h0);
        wr(enc_fb_pkg::off_term, 32'h2);
        repeat (25) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h1, 32'h1);
        irq_chk(1'b1);
        wr(enc_fb_pkg::off_mask, 32'h1);
        irq_chk(1'b0);
        wr(enc_fb_pkg::off_mask, 32'h0);
        mode <= 2'h0;
        repeat (4) @(posedge pclk);
        wr(enc_fb_pkg::off_status, 32'h1);
        rd_chk(enc_fb_pkg::off_status, 32'h1, 32'h0);
        irq_chk(1'b0);
        wr(enc_fb_pkg::off_type, 32'h7);
        wr(enc_fb_pkg::off_status, 32'h7);
        mode <= 2'h1;
        repeat (25) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h1, 32'h1);
        mode <= 2'h0;
        wr(enc_fb_pkg::off_type, 32'h1);
        $display("test wire done");
    endtask

    task automatic t_phase;
        logic [31:0] p;
        wr(enc_fb_pkg::off_errlvl, 32'h2);
        wr(enc_fb_pkg::off_status, 32'h7);
        mode <= 2'h2;
        repeat (10) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h2, 32'h0);
        mode <= 2'h0;
        wr(enc_fb_pkg::off_type, 32'h4);
        repeat (4) @(posedge pclk);
        chk({29'h0, comm_state}, 32'h5);
        @(negedge pclk);
        p = position;
        // one rising rate edge every 4 cycles, direction low counts up
        repeat (40) @(negedge pclk);
        chk(position - p, 32'h0000000a);
        @(posedge pclk);
        mode <= 2'h2;
        repeat (10) @(posedge pclk);
        rd_chk(enc_fb_pkg::off_status, 32'h2, 32'h2);
        irq_chk(1'b1);
        mode <= 2'h0;
        $display("test phase done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode = 2'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_types;
        t_supply;
        t_rate;
        t_auto;
        t_wire;
        t_phase;
        stop_test;
    end

    initial begin
        // whole run needs under a thousand cycles
        repeat (20000) @(posedge pclk);
        errors++;
        stop_test;
    end
endmodule // encoder_feedback_config_tb_top
